/* File: logic/eecc_ctrl.sv */
// Command, busy handshake and register file of the serial EEPROM controller.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module eecc_ctrl #(
  parameter logic [eecc_pkg::TMR_W-1:0] TIMEOUT_CYCLES = eecc_pkg::TMR_W'(eecc_pkg::TIMEOUT_CYCLES)
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [11:0]                 wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             irq_o,
  output logic                             op_start_o,
  output logic                             op_write_o,
  output logic      [eecc_pkg::ADDR_W-1:0] op_addr_o,
  output logic      [eecc_pkg::DATA_W-1:0] op_wdata_o,
  output logic                             op_abort_o,
  input  wire logic                        op_done_i,
  input  wire logic                        op_fail_i,
  input  wire logic [eecc_pkg::DATA_W-1:0] op_rdata_i,
  output logic                             loader_start_o,
  input  wire logic                        loader_done_i,
  input  wire logic                        loader_overflow_i
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Merges written bytes into a stored word according to the byte selects.
  function automatic logic [31:0] eecc_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  eecc_pkg::eecc_state_t             state_reg;
  eecc_pkg::eecc_state_t             state_next;
  logic [2:0]                        code_reg;
  logic [eecc_pkg::ADDR_W-1:0]       addr_reg;
  logic [eecc_pkg::DATA_W-1:0]       data_reg;
  logic                              timeout_reg;
  logic                              overflow_reg;
  logic [eecc_pkg::IRQ_W-1:0]        status_reg;
  logic [eecc_pkg::IRQ_W-1:0]        mask_reg;
  logic [eecc_pkg::IRQ_W-1:0]        status_set;
  logic                              ack_reg;
  logic [31:0]                       rdata_reg;
  logic                              op_start_reg;
  logic                              tmr_expired;
  logic                              busy;
  logic                              wb_req;
  logic                              wb_wr;
  logic                              cmd_wr;
  logic                              start_req;
  logic [2:0]                        start_code;
  logic                              code_bad;
  logic                              op_end;
  logic                              timeout_set;
  logic [31:0]                       cmd_word;
  logic [31:0]                       merged;
  logic [31:0]                       addr_merged;
  logic [31:0]                       mask_merged;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  assign wb_req     = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_wr      = wb_req && wb_we_i;
  assign cmd_wr     = wb_wr && (wb_adr_i == eecc_pkg::CMD_OFFSET);
  assign busy       = (state_reg != eecc_pkg::ST_IDLE);
  assign start_req  = cmd_wr && wb_sel_i[3] && wb_dat_i[eecc_pkg::BUSY_BIT] && !busy;
  assign start_code = wb_dat_i[eecc_pkg::CODE_MSB:eecc_pkg::CODE_LSB];
  assign code_bad   = (start_code != eecc_pkg::CODE_READ) && (start_code != eecc_pkg::CODE_WRITE)
                      && (start_code != eecc_pkg::CODE_RELOAD);
  assign op_end     = (state_reg == eecc_pkg::ST_RUN) && (op_done_i || op_fail_i || tmr_expired);
  assign timeout_set = tmr_expired || ((state_reg == eecc_pkg::ST_RUN) && op_fail_i)
                       || (start_req && code_bad);
  assign merged     = eecc_merge(32'h00000000, wb_dat_i, wb_sel_i);
  assign addr_merged = eecc_merge({16'h0000, addr_reg}, wb_dat_i, wb_sel_i);
  assign mask_merged = eecc_merge({29'h0, mask_reg}, wb_dat_i, wb_sel_i);

  // --------------------------------------------------------------------
  // Controller state machine
  // --------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      eecc_pkg::ST_BOOT: begin
        state_next = eecc_pkg::ST_LOAD;
      end
      eecc_pkg::ST_LOAD: begin
        if (loader_done_i) begin
          state_next = eecc_pkg::ST_IDLE;
        end
      end
      eecc_pkg::ST_IDLE: begin
        if (start_req && !code_bad) begin
          if (start_code == eecc_pkg::CODE_RELOAD) begin
            state_next = eecc_pkg::ST_BOOT;
          end else begin
            state_next = eecc_pkg::ST_RUN;
          end
        end
      end
      eecc_pkg::ST_RUN: begin
        if (op_end) begin
          state_next = eecc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = eecc_pkg::ST_IDLE;
      end
    endcase
  end

  // Reset enters the loader path, so busy reads one until loading ends.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= eecc_pkg::ST_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------
  // Command fields
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_reg <= eecc_pkg::CODE_RESET;
    end else if (cmd_wr && wb_sel_i[3] && !busy) begin
      code_reg <= start_code;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg <= eecc_pkg::ADDR_RESET;
    end else if (cmd_wr && !busy) begin
      addr_reg <= addr_merged[eecc_pkg::ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_reg <= eecc_pkg::DATA_RESET;
    end else if (op_done_i && (state_reg == eecc_pkg::ST_RUN) && !op_write_o) begin
      data_reg <= op_rdata_i;
    end else if (wb_wr && (wb_adr_i == eecc_pkg::DATA_OFFSET) && wb_sel_i[0] && !busy) begin
      data_reg <= wb_dat_i[7:0];
    end
  end

  // Timeout is write-one-to-clear; a new timeout in the same cycle wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_reg <= 1'b0;
    end else if (timeout_set) begin
      timeout_reg <= 1'b1;
    end else if (cmd_wr && wb_sel_i[2] && wb_dat_i[eecc_pkg::TIMEOUT_BIT]) begin
      timeout_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_reg <= 1'b0;
    end else if (loader_overflow_i) begin
      overflow_reg <= 1'b1;
    end else if (state_reg == eecc_pkg::ST_BOOT) begin
      overflow_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Operation engine handshake
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_start_reg <= 1'b0;
    end else begin
      op_start_reg <= (state_reg == eecc_pkg::ST_IDLE) && (state_next == eecc_pkg::ST_RUN);
    end
  end

  eecc_timer #(
    .LIMIT (TIMEOUT_CYCLES)
  ) u_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (state_reg == eecc_pkg::ST_RUN),
    .expired_o (tmr_expired)
  );

  assign op_start_o     = op_start_reg;
  assign op_write_o     = (code_reg == eecc_pkg::CODE_WRITE);
  assign op_addr_o      = addr_reg;
  assign op_wdata_o     = data_reg;
  assign op_abort_o     = tmr_expired && (state_reg == eecc_pkg::ST_RUN);
  assign loader_start_o = (state_reg == eecc_pkg::ST_BOOT);

  // --------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------
  assign status_set[eecc_pkg::IRQ_OP_DONE]   = op_end;
  assign status_set[eecc_pkg::IRQ_TIMEOUT]   = timeout_set;
  assign status_set[eecc_pkg::IRQ_LOAD_DONE] = (state_reg == eecc_pkg::ST_LOAD) && loader_done_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= eecc_pkg::IRQ_RESET;
    end else if (wb_wr && (wb_adr_i == eecc_pkg::STATUS_OFFSET)) begin
      status_reg <= (status_reg & ~merged[eecc_pkg::IRQ_W-1:0]) | status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= eecc_pkg::IRQ_RESET;
    end else if (wb_wr && (wb_adr_i == eecc_pkg::MASK_OFFSET)) begin
      mask_reg <= mask_merged[eecc_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(status_reg & mask_reg);

  // --------------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------------
  assign cmd_word = {busy, code_reg, 9'h000, overflow_reg, timeout_reg, 1'b0, addr_reg};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        eecc_pkg::CMD_OFFSET:    rdata_reg <= cmd_word;
        eecc_pkg::DATA_OFFSET:   rdata_reg <= {24'h000000, data_reg};
        eecc_pkg::STATUS_OFFSET: rdata_reg <= {29'h00000000, status_reg};
        eecc_pkg::MASK_OFFSET:   rdata_reg <= {29'h00000000, mask_reg};
        default:                 rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule

/* File: logic/eecc_pkg.sv */
// Constants, register map and state type of the EEPROM command controller.
package eecc_pkg;

  // --------------------------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [11:0] CMD_OFFSET    = 12'h1b4;
  localparam logic [11:0] DATA_OFFSET   = 12'h1b8;
  localparam logic [11:0] STATUS_OFFSET = 12'h1c0;
  localparam logic [11:0] MASK_OFFSET   = 12'h1c4;

  // --------------------------------------------------------------------
  // Command register fields
  // --------------------------------------------------------------------
  localparam int BUSY_BIT     = 31;
  localparam int CODE_MSB     = 30;
  localparam int CODE_LSB     = 28;
  localparam int OVERFLOW_BIT = 18;
  localparam int TIMEOUT_BIT  = 17;
  localparam int ADDR_W       = 16;
  localparam int DATA_W       = 8;

  localparam logic [2:0] CODE_RESET  = 3'h0;
  localparam logic [2:0] CODE_READ   = 3'h0;
  localparam logic [2:0] CODE_WRITE  = 3'h3;
  localparam logic [2:0] CODE_RELOAD = 3'h7;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // --------------------------------------------------------------------
  // Interrupt status and mask bits
  // --------------------------------------------------------------------
  localparam int IRQ_W          = 3;
  localparam int IRQ_OP_DONE    = 0;
  localparam int IRQ_TIMEOUT    = 1;
  localparam int IRQ_LOAD_DONE  = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ         = 25000000;
  localparam int TIMEOUT_MS     = 30;
  localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int TMR_W          = 20;

  // --------------------------------------------------------------------
  // Controller states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_LOAD = 2'b10,
    ST_BOOT = 2'b11
  } eecc_state_t;

endpackage

/* File: logic/eecc_timer.sv */
// Operation watchdog counter of the EEPROM command controller.
`timescale 1ns/1ps
module eecc_timer #(
  parameter logic [eecc_pkg::TMR_W-1:0] LIMIT = eecc_pkg::TMR_W'(eecc_pkg::TIMEOUT_CYCLES)
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      expired_o
);

  logic [eecc_pkg::TMR_W-1:0] count_reg;
  logic                       expired_reg;

  // Counting restarts whenever run_i drops, so each operation gets a full window.
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      count_reg <= '0;
    end else if (count_reg != LIMIT) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= (count_reg == LIMIT - 1'b1);
    end
  end

  assign expired_o = expired_reg;

endmodule

/* File: bench/eecc_ctrl_sva.sv */
// Concurrent checks on the ports of the EEPROM command controller.
`timescale 1ns/1ps
module eecc_ctrl_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        op_start_o,
  input wire logic        op_write_o,
  input wire logic [15:0] op_addr_o,
  input wire logic        op_abort_o,
  input wire logic        loader_start_o
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic cmd_go = wb_ack_o & wb_we_i & wb_dat_i[31] & (wb_adr_i == eecc_pkg::CMD_OFFSET);
  wire logic rld_go = cmd_go & (wb_dat_i[30:28] == eecc_pkg::CODE_RELOAD);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  a_start_cause: assert property (op_start_o |-> cmd_go)
    else $error("operation started without a busy bit write");
  a_start_fields: assert property (op_start_o |-> op_addr_o == $past(wb_dat_i[15:0])
    && op_write_o == ($past(wb_dat_i[30:28]) == eecc_pkg::CODE_WRITE))
    else $error("operation kind or location differs from the command");
  a_start_pulse: assert property (op_start_o |=> !op_start_o)
    else $error("start held longer than one cycle");
  a_abort_late: assert property (op_start_o |=> !op_abort_o [*8])
    else $error("abort came before the timeout span");
  a_abort_pulse: assert property (op_abort_o |=> !op_abort_o)
    else $error("abort held longer than one cycle");
  a_load_after_rst: assert property ($fell(rst_i) |-> ##[0:2] loader_start_o)
    else $error("loader not started after reset");
  a_load_cause: assert property (loader_start_o |-> $past(rst_i, 2) || $past(rst_i)
    || rld_go || $past(rld_go))
    else $error("loader started without reset or reload");
  c_write_op: cover property (op_start_o && op_write_o);
  c_abort: cover property (op_abort_o);
  c_reload: cover property (loader_start_o && rld_go);
endmodule
bind eecc_ctrl eecc_ctrl_chk u_eecc_ctrl_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .op_start_o, .op_write_o, .op_addr_o,
  .op_abort_o, .loader_start_o);

/* File: bench/eecc_eeprom_model.sv */
// Behavioural EEPROM engine and loader standing behind the controller.
`timescale 1ns/1ps
module eecc_eeprom_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        absent_i,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        abort_i,
  input  wire logic        load_i,
  output logic             done_o,
  output logic             fail_o,
  output logic      [7:0]  rdata_o,
  output logic             load_done_o,
  output logic             overflow_o
);
  logic [7:0] mem [16];
  logic [3:0] cnt, lcnt, a;
  logic [7:0] d;
  logic       w;
  assign fail_o = 1'b0;
  assign overflow_o = 1'b0;
  // An absent device never answers, so the count parks at one until abort.
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    load_done_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      cnt <= 4'h0;
      lcnt <= 4'h0;
      rdata_o <= 8'h00;
    end else begin
      if (start_i) begin
        cnt <= 4'h6;
        a <= addr_i[3:0];
        d <= wdata_i;
        w <= write_i;
      end else if (abort_i) begin
        cnt <= 4'h0;
      end else if (cnt == 4'h1 && !absent_i) begin
        cnt <= 4'h0;
        done_o <= 1'b1;
        if (w) mem[a] <= d;
        else rdata_o <= mem[a];
      end else if (cnt > 4'h1) cnt <= cnt - 4'h1;
      if (load_i) lcnt <= 4'h8;
      else if (lcnt == 4'h1) begin
        lcnt <= 4'h0;
        load_done_o <= 1'b1;
      end else if (lcnt > 4'h1) lcnt <= lcnt - 4'h1;
    end
  end
endmodule

/* File: bench/tb_eecc_ctrl.sv */
// Self-checking bench of the EEPROM command controller.
`timescale 1ns/1ps
module tb_eecc_ctrl;
  logic        clk_i = 1'b0, rst_i = 1'b1, absent = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, irq_o, op_start_o, op_write_o, op_abort_o, op_done_i, op_fail_i;
  logic        loader_start_o, loader_done_i, loader_overflow_i, aborted = 1'b0;
  logic [15:0] op_addr_o;
  logic [7:0]  op_wdata_o, op_rdata_i;
  int          err_total = 0, check_count = 0, loads = 0;
  always #20 clk_i = ~clk_i;
  eecc_ctrl #(.TIMEOUT_CYCLES(20'h00014)) u_eecc_ctrl (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .op_start_o,
    .op_write_o, .op_addr_o, .op_wdata_o, .op_abort_o, .op_done_i, .op_fail_i, .op_rdata_i,
    .loader_start_o, .loader_done_i, .loader_overflow_i);
  eecc_eeprom_model u_eecc_eeprom_model (.clk_i, .rst_i, .absent_i(absent),
    .start_i(op_start_o), .write_i(op_write_o), .addr_i(op_addr_o), .wdata_i(op_wdata_o),
    .abort_i(op_abort_o), .load_i(loader_start_o), .done_o(op_done_i), .fail_o(op_fail_i),
    .rdata_o(op_rdata_i), .load_done_o(loader_done_i), .overflow_o(loader_overflow_i));
  always @(posedge clk_i) begin
    if (op_abort_o === 1'b1) aborted <= 1'b1;
    if (loader_start_o === 1'b1) loads <= loads + 1;
  end
  // ------------------------------------------------------------------
  // Bus and checking tasks
  // ------------------------------------------------------------------
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [11:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wbusy;
    do rd(eecc_pkg::CMD_OFFSET); while (q[31] !== 1'b0);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_boot;
    rd(eecc_pkg::CMD_OFFSET);
    chk("busy after reset", q[31], 1'b1);
    wbusy;
    chk("command reset", q, 32'h0);
    rd(eecc_pkg::STATUS_OFFSET);
    chk("load done status", q, 32'h4);
    wr(eecc_pkg::STATUS_OFFSET, 32'h7);
    $display("boot test done");
  endtask
  task automatic t_write;
    wr(eecc_pkg::MASK_OFFSET, 32'h0);
    wr(eecc_pkg::DATA_OFFSET, 32'h5a);
    wr(eecc_pkg::CMD_OFFSET, 32'hb000_0012);
    wr(eecc_pkg::CMD_OFFSET, 32'h8000_0034);
    wr(eecc_pkg::DATA_OFFSET, 32'h77);
    wbusy;
    chk("command kept", q, 32'h3000_0012);
    rd(eecc_pkg::STATUS_OFFSET);
    chk("op end status", q, 32'h1);
    chk("irq masked", irq_o, 1'b0);
    wr(eecc_pkg::MASK_OFFSET, 32'h1);
    #1 chk("irq unmasked", irq_o, 1'b1);
    wr(eecc_pkg::STATUS_OFFSET, 32'h1);
    #1 chk("irq cleared", irq_o, 1'b0);
    wr(eecc_pkg::DATA_OFFSET, 32'h0);
    wr(eecc_pkg::CMD_OFFSET, 32'h8000_0012);
    wbusy;
    rd(eecc_pkg::DATA_OFFSET);
    chk("read back", q, 32'h5a);
    $display("write test done");
  endtask
  task automatic t_timeout;
    absent <= 1'b1;
    wr(eecc_pkg::CMD_OFFSET, 32'hb000_0020);
    rd(eecc_pkg::CMD_OFFSET);
    chk("busy while absent", q[31], 1'b1);
    wbusy;
    absent <= 1'b0;
    chk("timeout flag", q[17], 1'b1);
    chk("abort pulse", aborted, 1'b1);
    wb(1'b1, eecc_pkg::CMD_OFFSET, 32'h0002_0000, 4'h4);
    rd(eecc_pkg::CMD_OFFSET);
    chk("timeout cleared", q[17], 1'b0);
    wr(eecc_pkg::STATUS_OFFSET, 32'h7);
    $display("timeout test done");
  endtask
  task automatic t_reserved;
    logic [2:0] c [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    foreach (c[i]) begin
      wr(eecc_pkg::CMD_OFFSET, {1'b1, c[i], 28'h0});
      rd(eecc_pkg::CMD_OFFSET);
      chk("reserved code", q & 32'h8002_0000, 32'h0002_0000);
      wb(1'b1, eecc_pkg::CMD_OFFSET, 32'h0002_0000, 4'h4);
    end
    wr(eecc_pkg::STATUS_OFFSET, 32'h7);
    $display("reserved test done");
  endtask
  task automatic t_reload;
    int n;
    n = loads;
    wr(eecc_pkg::CMD_OFFSET, 32'hf000_0000);
    rd(eecc_pkg::CMD_OFFSET);
    chk("busy in reload", q[31], 1'b1);
    wbusy;
    chk("loader runs", loads, n + 1);
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100);
    chk("unmapped", q, 32'h0);
    $display("reload test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_boot;
    t_write;
    t_timeout;
    t_reserved;
    t_reload;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    test_done;
  end
endmodule
